/* File: hdl/bidir_fifo_cfg.svh */
// constants for the bidirectional dual-clock queue block
`ifndef BIDIR_FIFO_CFG_SVH
`define BIDIR_FIFO_CFG_SVH

`define QF_WIDTH 36
`define QF_ADDR_W 6
`define QF_OFFSET_HH 7'h10
`define QF_OFFSET_HL 7'h0C
`define QF_OFFSET_LH 7'h08
`define QF_OFFSET_LL 7'h04
`define QF_MAIL_RST 36'h000000000
`define QF_WORD_RST 36'h000000000

`endif

/* File: hdl/bidir_fifo_pkg.sv */
// types shared by the bidirectional dual-clock queue block
package bidir_fifo_pkg;

	typedef logic [35:0] word_t;

	typedef enum {
		FN_NONE,
		FN_QUEUE_WRITE,
		FN_MAIL_WRITE,
		FN_QUEUE_READ,
		FN_MAIL_READ
	} port_fn_t;

endpackage

/* File: hdl/bidir_fifo.sv */
// two-port dual-clock bidirectional queue with mailboxes
`timescale 1ns/1ps
`default_nettype none
`include "bidir_fifo_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// one direction: queue plus mailbox, write side on wclk, read side on rclk

module dc_queue #(
	parameter int WIDTH = `QF_WIDTH,
	parameter int ADDR_W = `QF_ADDR_W
) (
	input wire logic wclk,
	input wire logic wrst,
	input wire logic rclk,
	input wire logic rrst,
	input wire logic [ADDR_W:0] w_offset,
	input wire logic [ADDR_W:0] r_offset,
	input wire logic q_write,
	input wire logic [WIDTH-1:0] w_data,
	input wire logic q_read,
	output logic [WIDTH-1:0] r_data,
	output logic empty_n,
	output logic almost_empty_n,
	output logic full_n,
	output logic almost_full_n,
	input wire logic mail_write,
	input wire logic mail_read,
	output logic [WIDTH-1:0] mail_data,
	output logic mail_flag_n
);
	localparam int PW = ADDR_W + 1;
	localparam logic [PW-1:0] DEPTH = PW'(1 << ADDR_W);

	if (WIDTH < 1 || ADDR_W < 5)
	begin : g_chk
		$error("dc_queue: WIDTH or ADDR_W out of range");
	end

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b[PW-1] = g[PW-1];
		for (int i = PW - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

	////////////////////////////////////////////////////////////////////
	// write side

	logic [PW-1:0] wbin_reg;
	logic [PW-1:0] wgray_reg;
	// read-clock register, declared here since the write side syncs it
	logic [PW-1:0] rgray_reg;
	logic [PW-1:0] rgray_s1_reg;
	logic [PW-1:0] rgray_s2_reg;
	logic wrdy_reg;
	logic do_w;
	logic [PW-1:0] wbin_next;
	logic [PW-1:0] wgray_next;
	logic [PW-1:0] rbin_w;
	logic [PW-1:0] fill_w;
	logic full_hit;

	assign do_w = q_write & full_n;
	assign wbin_next = wbin_reg + PW'(do_w);
	assign wgray_next = wbin_next ^ (wbin_next >> 1);
	assign rbin_w = gray2bin(rgray_s2_reg);
	assign fill_w = wbin_next - rbin_w;
	assign full_hit = wgray_next ==
		{~rgray_s2_reg[PW-1:PW-2], rgray_s2_reg[PW-3:0]};

	always_ff @(posedge wclk)
	begin
		if (do_w)
			mem[wbin_reg[ADDR_W-1:0]] <= w_data;
	end

	always_ff @(posedge wclk or posedge wrst)
	begin
		if (wrst)
		begin
			wbin_reg <= '0;
			wgray_reg <= '0;
		end
		else
		begin
			wbin_reg <= wbin_next;
			wgray_reg <= wgray_next;
		end
	end

	// read pointer enters this domain only as gray code
	always_ff @(posedge wclk or posedge wrst)
	begin
		if (wrst)
		begin
			rgray_s1_reg <= '0;
			rgray_s2_reg <= '0;
		end
		else
		begin
			rgray_s1_reg <= rgray_reg;
			rgray_s2_reg <= rgray_s1_reg;
		end
	end

	// full stays low for one edge after release, rising on the second
	always_ff @(posedge wclk or posedge wrst)
	begin
		if (wrst)
		begin
			wrdy_reg <= 1'b0;
			full_n <= 1'b0;
			almost_full_n <= 1'b1;
		end
		else
		begin
			wrdy_reg <= 1'b1;
			full_n <= wrdy_reg & ~full_hit;
			almost_full_n <= fill_w < (DEPTH - w_offset);
		end
	end

	////////////////////////////////////////////////////////////////////
	// read side

	logic [PW-1:0] rbin_reg;
	logic [PW-1:0] wgray_s1_reg;
	logic [PW-1:0] wgray_s2_reg;
	logic do_r;
	logic [PW-1:0] rbin_next;
	logic [PW-1:0] rgray_next;
	logic [PW-1:0] fill_r;

	assign do_r = q_read & empty_n;
	assign rbin_next = rbin_reg + PW'(do_r);
	assign rgray_next = rbin_next ^ (rbin_next >> 1);
	assign fill_r = gray2bin(wgray_s2_reg) - rbin_next;

	always_ff @(posedge rclk or posedge rrst)
	begin
		if (rrst)
		begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			r_data <= WIDTH'(`QF_WORD_RST);
		end
		else
		begin
			rbin_reg <= rbin_next;
			rgray_reg <= rgray_next;
			if (do_r)
				r_data <= mem[rbin_reg[ADDR_W-1:0]];
		end
	end

	always_ff @(posedge rclk or posedge rrst)
	begin
		if (rrst)
		begin
			wgray_s1_reg <= '0;
			wgray_s2_reg <= '0;
		end
		else
		begin
			wgray_s1_reg <= wgray_reg;
			wgray_s2_reg <= wgray_s1_reg;
		end
	end

	// flags follow the second stage, never the first
	always_ff @(posedge rclk or posedge rrst)
	begin
		if (rrst)
		begin
			empty_n <= 1'b0;
			almost_empty_n <= 1'b0;
		end
		else
		begin
			empty_n <= rgray_next != wgray_s2_reg;
			almost_empty_n <= fill_r > r_offset;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mailbox: toggles cross, so a write and a read never collide

	logic mail_wtog_reg;
	logic rtog_s1_reg;
	logic rtog_s2_reg;
	logic mail_rtog_reg;
	logic wtog_s1_reg;
	logic wtog_s2_reg;
	logic mail_busy;
	logic rtog_next;

	assign mail_busy = mail_wtog_reg != rtog_s2_reg;
	assign rtog_next = mail_rtog_reg ^
		(mail_read & (wtog_s2_reg != mail_rtog_reg));

	always_ff @(posedge wclk or posedge wrst)
	begin
		if (wrst)
		begin
			mail_wtog_reg <= 1'b0;
			mail_data <= WIDTH'(`QF_MAIL_RST);
			rtog_s1_reg <= 1'b0;
			rtog_s2_reg <= 1'b0;
		end
		else
		begin
			rtog_s1_reg <= mail_rtog_reg;
			rtog_s2_reg <= rtog_s1_reg;
			// writes while mail is pending are dropped
			if (mail_write && !mail_busy)
			begin
				mail_data <= w_data;
				mail_wtog_reg <= ~mail_wtog_reg;
			end
		end
	end

	always_ff @(posedge rclk or posedge rrst)
	begin
		if (rrst)
		begin
			mail_rtog_reg <= 1'b0;
			wtog_s1_reg <= 1'b0;
			wtog_s2_reg <= 1'b0;
			mail_flag_n <= 1'b1;
		end
		else
		begin
			wtog_s1_reg <= mail_wtog_reg;
			wtog_s2_reg <= wtog_s1_reg;
			mail_rtog_reg <= rtog_next;
			mail_flag_n <= wtog_s2_reg == rtog_next;
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////
// top: port decode, bus drive, reset and offset capture per domain

// What this block does
// - bus driven only with select and read low
// - port A writes queue on enabled write
// - port A reads queue on enabled read
// - port B writes queue on enabled write
// - port B reads queue on enabled read
// - port A mail write, bus undriven
// - port A mail read raises its flag
// - port A read drives queue output register
// - port B mail write replaces queue write
// - port B mail read raises its flag
// - enable low means no transfer at all
// - flags pass two stages in own clock
// - reads ignored while empty flag low
// - read pointer advances per word read
// - empty flag rises after reader synchronisation
// - late edges start synchronisation one cycle later
// - writes ignored while full flag low
// - write pointer advances per word written
// - full flag rises after writer synchronisation
// - late edges start synchronisation one cycle later
// - almost empty low at offset or fewer
// - almost empty rises after reader synchronisation
// - long skew decides first synchronising edge
// - reset clears pointers and presets flags
// - offset taken from selects at release
// - almost full low at depth minus offset
module bidir_fifo #(
	parameter int ADDR_W = `QF_ADDR_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic b_port_clock,
	input wire logic offset_select_lo,
	input wire logic offset_select_hi,
	input wire logic a_chip_select_n,
	input wire logic a_write_read,
	input wire logic a_enable,
	input wire logic a_mail_select,
	input wire bidir_fifo_pkg::word_t a_data_in,
	output bidir_fifo_pkg::word_t a_data_out,
	output logic a_data_oe,
	input wire logic b_chip_select_n,
	input wire logic b_write_read,
	input wire logic b_enable,
	input wire logic b_mail_select,
	input wire bidir_fifo_pkg::word_t b_data_in,
	output bidir_fifo_pkg::word_t b_data_out,
	output logic b_data_oe,
	output logic a_empty_n,
	output logic a_almost_empty_n,
	output logic a_full_n,
	output logic a_almost_full_n,
	output logic b_empty_n,
	output logic b_almost_empty_n,
	output logic b_full_n,
	output logic b_almost_full_n,
	output logic a_to_b_mail_flag_n,
	output logic b_to_a_mail_flag_n
);
	import bidir_fifo_pkg::*;

	localparam int PW = ADDR_W + 1;
	localparam int WIDTH = $bits(word_t);

	function automatic port_fn_t decode(input logic cs_n, input logic wr,
		input logic en, input logic mb);
		port_fn_t f;
		f = FN_NONE;
		if (!cs_n && en)
		begin
			unique case ({wr, mb})
				2'h2: f = FN_QUEUE_WRITE;
				2'h3: f = FN_MAIL_WRITE;
				2'h0: f = FN_QUEUE_READ;
				2'h1: f = FN_MAIL_READ;
			endcase
		end
		return f;
	endfunction

	function automatic logic [PW-1:0] offset_of(input logic [1:0] sel);
		logic [PW-1:0] x;
		x = PW'(`QF_OFFSET_LL);
		unique case (sel)
			2'h3: x = PW'(`QF_OFFSET_HH);
			2'h2: x = PW'(`QF_OFFSET_HL);
			2'h1: x = PW'(`QF_OFFSET_LH);
			2'h0: x = PW'(`QF_OFFSET_LL);
		endcase
		return x;
	endfunction

	////////////////////////////////////////////////////////////////////
	// reset and offset capture, one copy per clock domain

	logic [1:0] rst_a_q;
	logic [1:0] rst_b_q;
	logic rst_a;
	logic rst_b;
	logic [1:0] sel_a_s1;
	logic [1:0] sel_a_s2;
	logic [1:0] sel_b_s1;
	logic [1:0] sel_b_s2;
	logic load_a_reg;
	logic load_b_reg;
	logic [PW-1:0] x_a_reg;
	logic [PW-1:0] x_b_reg;

	assign rst_a = rst_a_q[1];
	assign rst_b = rst_b_q[1];

	// asynchronous assert, release aligned to each port clock
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rst_a_q <= 2'h3;
		else
			rst_a_q <= {rst_a_q[0], 1'b0};
	end

	always_ff @(posedge b_port_clock or posedge rst)
	begin
		if (rst)
			rst_b_q <= 2'h3;
		else
			rst_b_q <= {rst_b_q[0], 1'b0};
	end

	// selects are static straps; they keep sampling through reset
	always_ff @(posedge clk)
	begin
		sel_a_s1 <= {offset_select_hi, offset_select_lo};
		sel_a_s2 <= sel_a_s1;
	end

	always_ff @(posedge b_port_clock)
	begin
		sel_b_s1 <= {offset_select_hi, offset_select_lo};
		sel_b_s2 <= sel_b_s1;
	end

	always_ff @(posedge clk or posedge rst_a)
	begin
		if (rst_a)
		begin
			load_a_reg <= 1'b1;
			x_a_reg <= PW'(`QF_OFFSET_LL);
		end
		else if (load_a_reg)
		begin
			load_a_reg <= 1'b0;
			x_a_reg <= offset_of(sel_a_s2);
		end
	end

	always_ff @(posedge b_port_clock or posedge rst_b)
	begin
		if (rst_b)
		begin
			load_b_reg <= 1'b1;
			x_b_reg <= PW'(`QF_OFFSET_LL);
		end
		else if (load_b_reg)
		begin
			load_b_reg <= 1'b0;
			x_b_reg <= offset_of(sel_b_s2);
		end
	end

	////////////////////////////////////////////////////////////////////
	// port decode

	port_fn_t fn_a;
	port_fn_t fn_b;

	assign fn_a = decode(a_chip_select_n, a_write_read, a_enable,
		a_mail_select);
	assign fn_b = decode(b_chip_select_n, b_write_read, b_enable,
		b_mail_select);

	////////////////////////////////////////////////////////////////////
	// the two directions

	word_t ab_rdata;
	word_t ab_mail;
	word_t ba_rdata;
	word_t ba_mail;

	dc_queue #(
		.WIDTH(WIDTH),
		.ADDR_W(ADDR_W)
	) u_a_to_b_queue (
		.wclk(clk),
		.wrst(rst_a),
		.rclk(b_port_clock),
		.rrst(rst_b),
		.w_offset(x_a_reg),
		.r_offset(x_b_reg),
		.q_write(fn_a == FN_QUEUE_WRITE),
		.w_data(a_data_in),
		.q_read(fn_b == FN_QUEUE_READ),
		.r_data(ab_rdata),
		.empty_n(b_empty_n),
		.almost_empty_n(b_almost_empty_n),
		.full_n(a_full_n),
		.almost_full_n(a_almost_full_n),
		.mail_write(fn_a == FN_MAIL_WRITE),
		.mail_read(fn_b == FN_MAIL_READ),
		.mail_data(ab_mail),
		.mail_flag_n(a_to_b_mail_flag_n)
	);

	dc_queue #(
		.WIDTH(WIDTH),
		.ADDR_W(ADDR_W)
	) u_b_to_a_queue (
		.wclk(b_port_clock),
		.wrst(rst_b),
		.rclk(clk),
		.rrst(rst_a),
		.w_offset(x_b_reg),
		.r_offset(x_a_reg),
		.q_write(fn_b == FN_QUEUE_WRITE),
		.w_data(b_data_in),
		.q_read(fn_a == FN_QUEUE_READ),
		.r_data(ba_rdata),
		.empty_n(a_empty_n),
		.almost_empty_n(a_almost_empty_n),
		.full_n(b_full_n),
		.almost_full_n(b_almost_full_n),
		.mail_write(fn_b == FN_MAIL_WRITE),
		.mail_read(fn_a == FN_MAIL_READ),
		.mail_data(ba_mail),
		.mail_flag_n(b_to_a_mail_flag_n)
	);

	////////////////////////////////////////////////////////////////////
	// bus drive is combinational: the pins turn round without a clock

	assign a_data_oe = ~a_chip_select_n & ~a_write_read;
	assign b_data_oe = ~b_chip_select_n & ~b_write_read;
	assign a_data_out = a_mail_select ? ba_mail : ba_rdata;
	assign b_data_out = b_mail_select ? ab_mail : ab_rdata;

endmodule

`default_nettype wire

/* File: tb/bidir_fifo_checker.sv */
// port-level assertions for the bidirectional queue block
`timescale 1ns/1ps
`default_nettype none
module bidir_fifo_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic b_port_clock,
	input wire logic a_chip_select_n,
	input wire logic a_write_read,
	input wire logic a_enable,
	input wire logic a_mail_select,
	input wire bidir_fifo_pkg::word_t a_data_out,
	input wire logic a_data_oe,
	input wire logic b_chip_select_n,
	input wire logic b_write_read,
	input wire logic b_enable,
	input wire logic b_mail_select,
	input wire logic b_data_oe,
	input wire logic a_empty_n,
	input wire logic a_almost_empty_n,
	input wire logic a_full_n,
	input wire logic a_almost_full_n,
	input wire logic b_empty_n,
	input wire logic b_full_n,
	input wire logic a_to_b_mail_flag_n,
	input wire logic b_to_a_mail_flag_n
);
	import bidir_fifo_pkg::*;
	a_drive_port_a: assert property (
		@(posedge clk) disable iff (rst)
		a_data_oe == (!a_chip_select_n && !a_write_read))
		else $error("port A drive enable wrong");
	a_drive_port_b: assert property (
		@(posedge b_port_clock) disable iff (rst)
		b_data_oe == (!b_chip_select_n && !b_write_read))
		else $error("port B drive enable wrong");
	a_hold_out_reg: assert property (
		@(posedge clk) disable iff (rst)
		(!a_mail_select && !(a_enable && a_empty_n && !a_chip_select_n
		&& !a_write_read)) ##1 !a_mail_select |-> $stable(a_data_out))
		else $error("port A output changed without a read");
	a_mail_clear_a: assert property (
		@(posedge clk) disable iff (rst)
		!a_chip_select_n && !a_write_read && a_enable && a_mail_select
		|=> b_to_a_mail_flag_n)
		else $error("port A mail read left flag low");
	a_mail_clear_b: assert property (
		@(posedge b_port_clock) disable iff (rst)
		!b_chip_select_n && !b_write_read && b_enable && b_mail_select
		|=> a_to_b_mail_flag_n)
		else $error("port B mail read left flag low");
	a_reset_flags: assert property (
		@(posedge clk) disable iff (rst) $fell(rst) |-> !a_empty_n
		&& !a_full_n && !a_almost_empty_n && a_almost_full_n)
		else $error("port A flags wrong at reset release");
	a_empty_on_read: assert property (
		@(posedge b_port_clock) disable iff (rst)
		!(!b_chip_select_n && !b_write_read && b_enable && !b_mail_select)
		|=> !$fell(b_empty_n))
		else $error("port B empty flag fell without a read");
	a_full_on_write: assert property (
		@(posedge b_port_clock) disable iff (rst)
		!(!b_chip_select_n && b_write_read && b_enable && !b_mail_select)
		|=> !$fell(b_full_n))
		else $error("port B full flag fell without a write");
	c_b_fill: cover property (@(posedge b_port_clock) $rose(b_empty_n));
	c_b_full: cover property (@(posedge b_port_clock) $fell(b_full_n));
	c_mail: cover property (@(posedge clk) $rose(b_to_a_mail_flag_n));
endmodule
bind bidir_fifo bidir_fifo_checker chk (.*);
`default_nettype wire

/* File: tb/b_side_host.sv */
// port B host model driving the far side of the block
`timescale 1ns/1ps
`default_nettype none
module b_side_host (
	input wire logic b_port_clock,
	output var logic b_chip_select_n,
	output var logic b_write_read,
	output var logic b_enable,
	output var logic b_mail_select,
	output var bidir_fifo_pkg::word_t b_data_in
);
	import bidir_fifo_pkg::*;
	initial
	begin
		b_chip_select_n = 1'b1;
		b_write_read = 1'b0;
		b_enable = 1'b0;
		b_mail_select = 1'b0;
		b_data_in = 36'h0;
	end
	// set just after an edge, held until the next edge takes it
	task automatic op(input logic cs_n, input logic wr, input logic en,
		input logic mb, input word_t d);
		@(posedge b_port_clock);
		#1;
		b_chip_select_n = cs_n;
		b_write_read = wr;
		b_enable = en;
		b_mail_select = mb;
		// a released bus must not keep showing the last word
		b_data_in = wr ? d : ~b_data_in;
	endtask
endmodule
`default_nettype wire

/* File: tb/bidir_fifo_tb.sv */
// self-checking bench for the bidirectional queue block
`timescale 1ns/1ps
`default_nettype none
module bidir_fifo_tb;
	import bidir_fifo_pkg::*;
	localparam int X = 12;
	logic clk = 1'b0;
	logic b_port_clock = 1'b0;
	logic rst = 1'b1;
	logic offset_select_lo = 1'b0;
	logic offset_select_hi = 1'b1;
	logic a_chip_select_n = 1'b1;
	logic a_write_read = 1'b0;
	logic a_enable = 1'b0;
	logic a_mail_select = 1'b0;
	word_t a_data_in = 36'h0;
	word_t a_data_out, b_data_out, b_data_in;
	logic a_data_oe, b_data_oe, a_to_b_mail_flag_n, b_to_a_mail_flag_n;
	logic b_chip_select_n, b_write_read, b_enable, b_mail_select;
	logic a_empty_n, a_almost_empty_n, a_full_n, a_almost_full_n;
	logic b_empty_n, b_almost_empty_n, b_full_n, b_almost_full_n;
	int failures = 0;
	int tests_run = 0;
	always #10 clk = ~clk;
	initial
	begin
		#4;
		forever #15 b_port_clock = ~b_port_clock;
	end
	bidir_fifo dut (.*);
	b_side_host far (.*);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input word_t seen, input word_t exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	function automatic word_t flags();
		return {26'h0, a_to_b_mail_flag_n, b_to_a_mail_flag_n, a_empty_n,
			a_almost_empty_n, a_full_n, a_almost_full_n, b_empty_n,
			b_almost_empty_n, b_full_n, b_almost_full_n};
	endfunction
	task automatic a_op(input logic cs_n, input logic wr, input logic en,
		input logic mb, input word_t d);
		@(posedge clk);
		#1;
		a_chip_select_n = cs_n;
		a_write_read = wr;
		a_enable = en;
		a_mail_select = mb;
		a_data_in = wr ? d : ~a_data_in;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_stream;
		a_op(1'b0, 1'b1, 1'b0, 1'b0, 36'hBAD);
		for (int i = 0; i < X; i++)
			a_op(1'b0, 1'b1, 1'b1, 1'b0, 36'(i + 100));
		a_op(1'b1, 1'b0, 1'b0, 1'b0, 36'h0);
		repeat (8) @(posedge b_port_clock);
		#1;
		chk(36'({b_empty_n, b_almost_empty_n}), 36'h2);
		a_op(1'b0, 1'b1, 1'b1, 1'b0, 36'(X + 100));
		a_op(1'b1, 1'b0, 1'b0, 1'b0, 36'h0);
		repeat (8) @(posedge b_port_clock);
		#1;
		chk(36'(b_almost_empty_n), 36'h1);
		for (int i = 0; i <= X + 1; i++)
		begin
			far.op(1'b0, 1'b0, 1'b1, 1'b0, 36'h0);
			far.op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
			chk(b_data_out, 36'(i > X ? X + 100 : i + 100));
		end
		chk(36'(b_empty_n), 36'h0);
		$display("stream test done");
	endtask
	task automatic t_full;
		// one word more than fits, so the last write is refused
		for (int i = 0; i < 65; i++)
			far.op(1'b0, 1'b1, 1'b1, 1'b0, 36'(i + 500));
		far.op(1'b1, 1'b0, 1'b0, 1'b0, 36'h0);
		chk(36'({b_full_n, b_almost_full_n}), 36'h0);
		repeat (8) @(posedge clk);
		for (int i = 0; i < 65; i++)
		begin
			a_op(1'b0, 1'b0, 1'b1, 1'b0, 36'h0);
			a_op(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
			chk(a_data_out, 36'(i < 64 ? i + 500 : 563));
		end
		repeat (8) @(posedge b_port_clock);
		#1;
		chk(36'({b_full_n, b_almost_full_n}), 36'h3);
		$display("full test done");
	endtask
	task automatic t_mail;
		a_op(1'b0, 1'b1, 1'b1, 1'b1, 36'hA5A5A5A5A);
		a_op(1'b1, 1'b0, 1'b0, 1'b0, 36'h0);
		repeat (8) @(posedge b_port_clock);
		#1;
		chk(36'({b_empty_n, a_to_b_mail_flag_n}), 36'h0);
		far.op(1'b0, 1'b0, 1'b1, 1'b1, 36'h0);
		far.op(1'b0, 1'b0, 1'b0, 1'b1, 36'h0);
		chk(b_data_out, 36'hA5A5A5A5A);
		chk(36'(a_to_b_mail_flag_n), 36'h1);
		far.op(1'b0, 1'b1, 1'b1, 1'b1, 36'h3C3C3C3C3);
		far.op(1'b1, 1'b0, 1'b0, 1'b0, 36'h0);
		repeat (8) @(posedge clk);
		#1;
		chk(36'({a_empty_n, b_to_a_mail_flag_n}), 36'h0);
		a_op(1'b0, 1'b0, 1'b1, 1'b1, 36'h0);
		a_op(1'b0, 1'b0, 1'b0, 1'b1, 36'h0);
		chk(a_data_out, 36'h3C3C3C3C3);
		chk(36'(b_to_a_mail_flag_n), 36'h1);
		$display("mail test done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		// longer than two cycles so port B also sees four edges
		repeat (6) @(posedge clk);
		chk(flags(), 36'h311);
		#1;
		rst = 1'b0;
		repeat (10) @(posedge clk);
		chk(flags(), 36'h333);
		t_stream();
		t_full();
		t_mail();
		test_done();
	end
	initial
	begin
		#100000;
		failures++;
		test_done();
	end
endmodule
`default_nettype wire
